// *** rtl/bac_regs.sv ***
// Bus area configuration registers with external cycle sequencer
// Assumes APB master on ref_clk; power-on reset separate from manual reset
// Functional notes
// [RL1] Memory-type field selects area 2/3 kinds
// [RL2] Non-normal type needs word width areas 2,3
// [RL3] Both-DRAM makes endian pin carry row strobe
// [RL4] Area 5 card bit: card space, pin three
// [RL5] Area 6 card bit: card space, pin four
// [RL6] Width register reset only at power-on
// [RL7] Only area 0 until width initialised
// [RL8] Reserved bits read zero, write zero
// [RL9] Per-area width codes, 32-bit reset value
// [RL10] Port mode forbids 32-bit width code
// [RL11] Port enable turns mid data byte into port
// [RL12] Idle cycles on area change or read-write
// [RL13] Idle register reset only at power-on
// [RL14] Per-area idle count 0..3, reset 3
// [RL15] Settings sampled at each cycle start
// [RL16] Reserved codes give undefined behaviour
`timescale 1ns/1ps
module bac_regs
    import bac_pkg::*;
(
    // Clock and resets
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic manualReset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External cycle request
    input wire logic cycleReq,
    input wire logic [2:0] cycleArea,
    input wire logic cycleWrite,
    output logic cycleStart,
    output logic [1:0] cycleWidth,
    output logic cycleIdle,
    output logic [2:0] cycleMemKind,
    output logic cycleCard,
    output logic cycleWidthBad,
    // Pin functions
    output logic endianPinIsRowStrobe,
    output logic modePinThreeIsCardEnable,
    output logic modePinFourIsCardEnable,
    output logic dataMidBytePortEn,
    output logic widthInitDone
);
    logic [15:0] areaType;
    logic [15:0] widthPort;
    logic [15:0] idleCtrl;
    logic [15:0] readWord;
    logic accessPhase;
    logic wrTake;
    logic [1:0] idleSel;
    logic idleBusy;
    logic idleNeeded;
    logic haveLast;
    logic [2:0] lastArea;
    logic lastWrite;
    logic [2:0] memtypeSel;
    logic startNow;
    logic [1:0] widthCode;
    logic [2:0] next_memKind;
    logic idleDone;
    logic idleGap;
    logic idleLoad;
    logic [1:0] idleLoadValue;
    logic manualSync1;
    logic manualSync2;

    assign accessPhase = psel && penable && !pready;
    assign wrTake = psel && penable && pready && pwrite;
    assign memtypeSel = areaType[BAC_MEMTYPE_LSB +: 3];

    // APB single-wait answer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= accessPhase;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= accessPhase && (paddr > BAC_CTRL_OFS || paddr[1:0] != 2'h0);
        end
    end

    // Manual reset pin through two flops
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            manualSync1 <= 1'b0;
            manualSync2 <= 1'b0;
        end else begin
            manualSync1 <= manualReset;
            manualSync2 <= manualSync1;
        end
    end

    // Type register, cleared by any reset
    always_ff @(posedge ref_clk) begin
        if (reset || manualSync2) begin
            areaType <= BAC_TYPE_RST;
        end else if (wrTake && paddr == BAC_TYPE_OFS) begin
            areaType <= pwdata[15:0] & BAC_TYPE_MASK; // RL1
        end
    end

    // Width register, power-on reset only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            widthPort <= BAC_WIDTH_RST; // RL6
        end else if (wrTake && paddr == BAC_WIDTH_OFS) begin
            widthPort <= pwdata[15:0] & BAC_WIDTH_MASK; // RL8
        end
    end

    // Idle register, power-on reset only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            idleCtrl <= BAC_IDLE_RST; // RL13
        end else if (wrTake && paddr == BAC_IDLE_OFS) begin
            idleCtrl <= pwdata[15:0] & BAC_IDLE_MASK; // RL8
        end
    end

    // Width init flag, set by first width write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            widthInitDone <= 1'b0;
        end else if (wrTake && paddr == BAC_WIDTH_OFS) begin
            widthInitDone <= 1'b1; // RL7
        end
    end

    always_comb begin
        unique case (paddr)
            BAC_TYPE_OFS: readWord = areaType;
            BAC_WIDTH_OFS: readWord = widthPort; // RL8
            BAC_IDLE_OFS: readWord = idleCtrl;
            BAC_CTRL_OFS: readWord = {15'h0000, widthInitDone};
            default: readWord = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (accessPhase && !pwrite) begin
            prdata <= {16'h0000, readWord};
        end
    end

    // Pin function selects
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            endianPinIsRowStrobe <= 1'b0;
            modePinThreeIsCardEnable <= 1'b0;
            modePinFourIsCardEnable <= 1'b0;
            dataMidBytePortEn <= 1'b0;
        end else begin
            endianPinIsRowStrobe <= (memtypeSel == BAC_MT_BOTH_DRAM); // RL3
            modePinThreeIsCardEnable <= areaType[BAC_AREA5_CARD_BIT]; // RL4
            modePinFourIsCardEnable <= areaType[BAC_AREA6_CARD_BIT]; // RL5
            dataMidBytePortEn <= widthPort[BAC_PORT_EN_BIT]; // RL11
        end
    end

    // Idle need: area change or read then write
    assign idleSel = haveLast ? idleCtrl[{lastArea, 1'b0} +: 2] : 2'h0; // RL14
    assign idleNeeded = haveLast && !idleDone
        && (lastArea != cycleArea || (!lastWrite && cycleWrite)); // RL12
    assign idleGap = idleNeeded && idleSel != 2'h0;
    assign idleLoad = cycleReq && !idleBusy && idleGap;
    assign idleLoadValue = idleSel - 2'h1;
    assign startNow = cycleReq && !idleBusy && !idleGap && !cycleStart;

    // Start is held off exactly the programmed number of cycles
    bac_idle_counter idleCount (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(idleLoad),
        .loadValue(idleLoadValue),
        .busy(idleBusy)
    );

    // Idle window served once per waiting request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            idleDone <= 1'b0;
        end else if (cycleStart) begin
            idleDone <= 1'b0;
        end else if (idleLoad) begin
            idleDone <= 1'b1;
        end
    end

    // Marks the pending idle window before a start
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cycleIdle <= 1'b0;
        end else begin
            cycleIdle <= idleLoad || (cycleIdle && !startNow); // RL12
        end
    end

    // Last cycle record
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            haveLast <= 1'b0;
            lastArea <= 3'h0;
            lastWrite <= 1'b0;
        end else if (cycleStart) begin
            haveLast <= 1'b1;
            lastArea <= cycleArea;
            lastWrite <= cycleWrite;
        end
    end

    // Area decode of width and kind
    always_comb begin
        widthCode = BAC_SZ_LONG;
        next_memKind = BAC_MEM_NORMAL;
        if (cycleArea != 3'h0 && cycleArea < 3'(BAC_NUM_AREAS)) begin
            widthCode = widthPort[{cycleArea, 1'b0} +: 2]; // RL9
        end
        if (cycleArea == 3'h3) begin
            unique case (memtypeSel)
                BAC_MT_A3_PSRAM: next_memKind = BAC_MEM_PSRAM;
                BAC_MT_A3_SDRAM, BAC_MT_BOTH_SDRAM: next_memKind = BAC_MEM_DRAM;
                BAC_MT_A3_DRAM, BAC_MT_BOTH_DRAM: next_memKind = BAC_MEM_DRAM;
                default: next_memKind = BAC_MEM_NORMAL; // RL16
            endcase
        end else if (cycleArea == 3'h2) begin
            if (memtypeSel == BAC_MT_BOTH_SDRAM || memtypeSel == BAC_MT_BOTH_DRAM) begin
                next_memKind = BAC_MEM_DRAM;
            end
        end
    end

    // Settings captured at cycle start
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cycleStart <= 1'b0;
            cycleWidth <= BAC_SZ_LONG;
            cycleMemKind <= BAC_MEM_NORMAL;
            cycleCard <= 1'b0;
            cycleWidthBad <= 1'b0;
        end else begin
            cycleStart <= startNow;
            if (startNow) begin
                cycleWidth <= widthCode; // RL15
                cycleMemKind <= next_memKind; // RL1
                cycleCard <= (cycleArea == 3'h5 && areaType[BAC_AREA5_CARD_BIT])
                    || (cycleArea == 3'h6 && areaType[BAC_AREA6_CARD_BIT]);
                cycleWidthBad <= (widthCode == 2'h0)
                    || (widthPort[BAC_PORT_EN_BIT] && widthCode == BAC_SZ_LONG) // RL10
                    || (cycleArea != 3'h0 && !widthInitDone) // RL7
                    || (memtypeSel != BAC_MT_NORMAL && (cycleArea == 3'h2 || cycleArea == 3'h3)
                        && widthCode != BAC_SZ_WORD); // RL2
            end
        end
    end
endmodule // bac_regs

// *** pkg/bac_pkg.sv ***
// Package: register map, field layout and reset values of the bus area config block
// Assumes a 32-bit APB slave with one aligned word per register
package bac_pkg;
    localparam logic [11:0] BAC_TYPE_OFS = 12'h000;
    localparam logic [11:0] BAC_WIDTH_OFS = 12'h004;
    localparam logic [11:0] BAC_IDLE_OFS = 12'h008;
    localparam logic [11:0] BAC_CTRL_OFS = 12'h00C;
    localparam logic [15:0] BAC_TYPE_RST = 16'h0000;
    localparam logic [15:0] BAC_WIDTH_RST = 16'h3FFC;
    localparam logic [15:0] BAC_IDLE_RST = 16'h3FFF;
    localparam logic [15:0] BAC_TYPE_MASK = 16'h001F;
    localparam logic [15:0] BAC_WIDTH_MASK = 16'h3FFD;
    localparam logic [15:0] BAC_IDLE_MASK = 16'h3FFF;
    localparam int BAC_MEMTYPE_LSB = 2;
    localparam int BAC_AREA5_CARD_BIT = 1;
    localparam int BAC_AREA6_CARD_BIT = 0;
    localparam int BAC_PORT_EN_BIT = 0;
    localparam int BAC_NUM_AREAS = 7;
    localparam logic [2:0] BAC_MT_NORMAL = 3'h0;
    localparam logic [2:0] BAC_MT_A3_PSRAM = 3'h1;
    localparam logic [2:0] BAC_MT_A3_SDRAM = 3'h2;
    localparam logic [2:0] BAC_MT_BOTH_SDRAM = 3'h3;
    localparam logic [2:0] BAC_MT_A3_DRAM = 3'h4;
    localparam logic [2:0] BAC_MT_BOTH_DRAM = 3'h5;
    localparam logic [1:0] BAC_SZ_BYTE = 2'h1;
    localparam logic [1:0] BAC_SZ_WORD = 2'h2;
    localparam logic [1:0] BAC_SZ_LONG = 2'h3;
    localparam logic [2:0] BAC_AREA_BITS = 3'h3;
    typedef enum logic [2:0] {
        BAC_MEM_NORMAL = 3'h1,
        BAC_MEM_PSRAM = 3'h2,
        BAC_MEM_DRAM = 3'h4
    } bac_memkind_t;
endpackage

// *** rtl/bac_idle_counter.sv ***
// Idle cycle counter placed between external bus cycles
// Assumes load and count come from the same clock domain
`timescale 1ns/1ps
module bac_idle_counter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [1:0] loadValue,
    // Status
    output logic busy
);
    logic [1:0] count;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count <= 2'h0;
        end else if (load) begin
            count <= loadValue;
        end else if (count != 2'h0) begin
            count <= count - 2'h1;
        end
    end

    assign busy = (count != 2'h0);
endmodule // bac_idle_counter

// *** verif/bac_regs_monitor.sv ***
// Checker: port properties of the bus area config registers
// Assumes binding to bac_regs, one clock
`timescale 1ns/1ps
module bac_regs_monitor
    import bac_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Cycle port and pins
    input wire logic cycleReq,
    input wire logic [2:0] cycleArea,
    input wire logic cycleStart,
    input wire logic [1:0] cycleWidth,
    input wire logic [2:0] cycleMemKind,
    input wire logic endianPinIsRowStrobe,
    input wire logic modePinThreeIsCardEnable,
    input wire logic modePinFourIsCardEnable,
    input wire logic dataMidBytePortEn
);
    logic [31:0] lastData;
    logic wrDone;
    assign wrDone = psel && penable && pready && pwrite;
    always_ff @(posedge ref_clk) begin
        if (psel && penable && pready) begin
            lastData <= pwdata;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    AST_RSV_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("Upper read half not zero");
    AST_ROW_STROBE: assert property (wrDone && paddr == BAC_TYPE_OFS
        |-> ##2 endianPinIsRowStrobe == (lastData[4:2] == BAC_MT_BOTH_DRAM)) else $error("Row strobe select wrong");
    AST_PIN_THREE: assert property (wrDone && paddr == BAC_TYPE_OFS
        |-> ##2 modePinThreeIsCardEnable == lastData[1]) else $error("Pin three select wrong");
    AST_PIN_FOUR: assert property (wrDone && paddr == BAC_TYPE_OFS
        |-> ##2 modePinFourIsCardEnable == lastData[0]) else $error("Pin four select wrong");
    AST_PORT_EN: assert property (wrDone && paddr == BAC_WIDTH_OFS
        |-> ##2 dataMidBytePortEn == lastData[0]) else $error("Port enable wrong");
    AST_START_BOUND: assert property (cycleReq && !cycleStart |-> ##[1:8] cycleStart)
        else $error("Cycle start late");
    AST_AREA0_LONG: assert property (cycleStart && cycleArea == 3'h0 |-> cycleWidth == BAC_SZ_LONG)
        else $error("Area 0 width wrong");
    AST_KIND_NORMAL: assert property (cycleStart && (cycleArea < 3'h2 || cycleArea > 3'h3)
        |-> cycleMemKind == 3'h1) else $error("Memory kind wrong");
endmodule // bac_regs_monitor

// *** verif/bac_mem_side.sv ***
// Far-side requester: raises external cycle requests
// Assumes the cycle port contract; holds each request until cycleStart
`timescale 1ns/1ps
module bac_mem_side (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Bench commands
    input wire logic reqGo,
    input wire logic [2:0] reqArea,
    input wire logic reqWrite,
    input wire logic widthInitDone,
    // Cycle port
    input wire logic cycleStart,
    output logic cycleReq,
    output logic [2:0] cycleArea,
    output logic cycleWrite
);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cycleReq <= 1'h0;
            cycleArea <= 3'h0;
            cycleWrite <= 1'h0;
        end else if (reqGo && (reqArea == 3'h0 || widthInitDone)) begin
            cycleReq <= 1'h1;
            cycleArea <= reqArea;
            cycleWrite <= reqWrite;
        end else if (cycleStart) begin
            cycleReq <= 1'h0;
        end
    end
endmodule // bac_mem_side

// *** verif/tb_bus_area_config_regs.sv ***
// Testbench: APB register accesses and external cycle requests
// Assumes bac_regs with one-wait-state APB and the far-side requester
`timescale 1ns/1ps
module tb_bus_area_config_regs;
    import bac_pkg::*;
    logic ref_clk = 1'h0, reset = 1'h1, manualReset = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, cycleReq, cycleWrite, cycleStart, cycleIdle, cycleCard, cycleWidthBad;
    logic [2:0] cycleArea, cycleMemKind;
    logic [1:0] cycleWidth;
    logic endianPinIsRowStrobe, modePinThreeIsCardEnable, modePinFourIsCardEnable, dataMidBytePortEn, widthInitDone;
    logic reqGo = 1'h0, reqWrite = 1'h0;
    logic [2:0] reqArea = 3'h0;
    int n_errors = 0, checks = 0, lat, idl, tick = 0;
    bac_regs u_bac_regs (.*);
    bac_mem_side u_bac_mem_side (.*);
    initial forever #4 ref_clk = ~ref_clk;
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic cyc(input logic [2:0] a, input logic w);
        @(posedge ref_clk);
        reqGo <= 1'h1;
        reqArea <= a;
        reqWrite <= w;
        @(posedge ref_clk);
        reqGo <= 1'h0;
        lat = 0;
        idl = 0;
        while (cycleStart !== 1'h1) begin
            @(posedge ref_clk);
            lat++;
            if (cycleIdle === 1'h1) idl++;
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        tick++;
        if (tick == 4000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'h0;
        apb(1'h0, BAC_TYPE_OFS, 32'h0);
        chk("type", 32'h0, rd);
        apb(1'h0, BAC_WIDTH_OFS, 32'h0);
        chk("width", 32'h3FFC, rd);
        apb(1'h0, BAC_IDLE_OFS, 32'h0);
        chk("idle", 32'h3FFF, rd);
        apb(1'h0, BAC_CTRL_OFS, 32'h0);
        chk("init", 32'h0, rd);
        cyc(3'h0, 1'h0);
        cyc(3'h0, 1'h0);
        chk("lat_rr", 32'h2, lat);
        cyc(3'h0, 1'h1);
        chk("lat_rw", 32'h5, lat);
        chk("idle_rw", 32'h3, idl);
        apb(1'h1, BAC_WIDTH_OFS, 32'h3FAC);
        apb(1'h0, BAC_CTRL_OFS, 32'h0);
        chk("init", 32'h1, rd);
        apb(1'h1, BAC_IDLE_OFS, 32'h0);
        cyc(3'h1, 1'h0);
        cyc(3'h2, 1'h0);
        chk("lat_chg", 32'h2, lat);
        chk("idle_chg", 32'h0, idl);
        chk("width2", 32'h2, cycleWidth);
        for (int m = 0; m < 6; m++) begin
            apb(1'h1, BAC_TYPE_OFS, m << 2);
            apb(1'h0, BAC_TYPE_OFS, 32'h0);
            chk("type", m << 2, rd);
            cyc(3'h3, 1'h0);
            chk("kind3", m == 0 ? 32'h1 : (m == 1 ? 32'h2 : 32'h4), cycleMemKind);
        end
        chk("bad3", 32'h0, cycleWidthBad);
        apb(1'h1, BAC_TYPE_OFS, 32'h17);
        repeat (2) @(posedge ref_clk);
        chk("pins", 32'h7, {endianPinIsRowStrobe, modePinThreeIsCardEnable, modePinFourIsCardEnable});
        cyc(3'h5, 1'h0);
        chk("card5", 32'h1, cycleCard);
        apb(1'h1, BAC_WIDTH_OFS, 32'h2AA9);
        apb(1'h0, BAC_WIDTH_OFS, 32'h0);
        chk("width", 32'h2AA9, rd);
        chk("port", 32'h1, dataMidBytePortEn);
        apb(1'h1, BAC_WIDTH_OFS, 32'h2BA9);
        cyc(3'h4, 1'h0);
        chk("bad4", 32'h1, cycleWidthBad);
        @(posedge ref_clk);
        manualReset <= 1'h1;
        @(posedge ref_clk);
        manualReset <= 1'h0;
        apb(1'h0, BAC_WIDTH_OFS, 32'h0);
        chk("width_mr", 32'h2BA9, rd);
        apb(1'h0, BAC_IDLE_OFS, 32'h0);
        chk("idle_mr", 32'h0, rd);
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {rd != 32'h0, err});
        give_verdict;
    end
endmodule // tb_bus_area_config_regs
bind bac_regs bac_regs_monitor u_bac_regs_monitor (.*);
